// File: inc/fpd_regs.svh
// Field positions, encodings and reset values for the floating-point slot decoder
// ****************************************************************
// Operation
// - Classify slot by major opcode group
// - Bit 33 picks extension lookup or reciprocal
// - Six-bit extension taken from bits 32:27
// - Bit 36 picks reciprocal or square root
// - Opcode zero whole, opcode one paired
// - Bits 35:34 report status field select
// - Opcodes 8-D decode multiply-add family
// - Opcode E, bit 36 clear: select
// - Opcode E, bit 36 set: integer multiply-add
// - Opcode 4 compare, bit 12 unconditional
// - Opcode 5 class test, bit 12 unconditional
// - Opcode zero control and conversion extensions
// - Extensions 14-17 minimum and maximum forms
// - Opcode one extensions 30-37 paired compares
// - Merge forms and paired conversions
// - Opcode zero pack, logic, swap, mix, extend
// ****************************************************************
`ifndef FPD_REGS_SVH
`define FPD_REGS_SVH

// ****************************************************************
// Slot fields
// ****************************************************************
`define FPD_OPC_HI     40
`define FPD_OPC_LO     37
`define FPD_Q_BIT      36
`define FPD_STAT_HI    35
`define FPD_STAT_LO    34
`define FPD_X_BIT      33
`define FPD_EXT_HI     32
`define FPD_EXT_LO     27
`define FPD_TA_BIT     12
`define FPD_DST_LO     6
`define FPD_SRC1_LO    13
`define FPD_SRC2_LO    20
`define FPD_SRC3_LO    27
`define FPD_PRED_LO    0
`define FPD_REG_W      7
`define FPD_PRED_W     6

// ****************************************************************
// Major opcodes and selector values
// ****************************************************************
`define FPD_OPC_MISC0  4'h0
`define FPD_OPC_MISC1  4'h1
`define FPD_OPC_CMP    4'h4
`define FPD_OPC_CLASS  4'h5
`define FPD_OPC_FMA_LO 4'h8
`define FPD_OPC_FMA_HI 4'hD
`define FPD_OPC_XMA    4'hE
`define FPD_MUL_LOW    2'h0
`define FPD_MUL_HU     2'h2
`define FPD_MUL_H      2'h3

// ****************************************************************
// Reset values
// ****************************************************************
`define FPD_RST_REG    7'h00
`define FPD_RST_PRED   6'h00
`define FPD_RST_STAT   2'h0

`endif

// File: inc/fpd_pkg.sv
// Types shared by the floating-point slot decoder
package fpd_pkg;

  typedef logic [40:0] fpd_slot_t;
  typedef logic [6:0]  fpd_reg_t;
  typedef logic [5:0]  fpd_pred_t;
  typedef logic [1:0]  fpd_stat_t;

  typedef enum logic [2:0] {
    GRP_NONE, GRP_MISC, GRP_RECIP, GRP_FMA, GRP_XMA_SEL, GRP_CMP, GRP_CLASS
  } fpd_grp_e;

  typedef enum logic [1:0] {
    FMT_WHOLE, FMT_SINGLE, FMT_DOUBLE, FMT_PAIRED
  } fpd_fmt_e;

  typedef enum logic [5:0] {
    OP_NONE, OP_BREAK, OP_NOP, OP_SETC, OP_CLRF, OP_CHKF,
    OP_MERGE_S, OP_MERGE_NS, OP_MERGE_SE,
    OP_MIN, OP_MAX, OP_AMIN, OP_AMAX,
    OP_CVT_FX, OP_CVT_FXU, OP_CVT_FX_TRUNC, OP_CVT_FXU_TRUNC, OP_CVT_XF,
    OP_PACK, OP_AND, OP_ANDCM, OP_OR, OP_XOR,
    OP_SWAP, OP_SWAP_NL, OP_SWAP_NR, OP_MIX_LR, OP_MIX_R, OP_MIX_L,
    OP_SXT_R, OP_SXT_L,
    OP_CMP_EQ, OP_CMP_LT, OP_CMP_LE, OP_CMP_UNORD,
    OP_CMP_NEQ, OP_CMP_NLT, OP_CMP_NLE, OP_CMP_ORD,
    OP_RCPA, OP_RSQRTA, OP_MA, OP_MS, OP_NMA,
    OP_XMA_L, OP_XMA_HU, OP_XMA_H, OP_SELECT, OP_CLASS
  } fpd_op_e;

endpackage

// File: rtl/fpd_field.sv
// Bit-field slice of an instruction slot
`timescale 1ns/1ps
module fpd_field #(
  parameter int LSB = 0,
  parameter int W   = 7
) (
  input  wire logic [40:0]  slot,
  output logic      [W-1:0] field
);
  assign field = slot[LSB +: W];
endmodule

// File: rtl/fpd_ext_lookup.sv
// Six-bit extension lookup for major opcodes zero and one
`timescale 1ns/1ps
module fpd_ext_lookup (
  input  wire logic         opc_one,
  input  wire logic [5:0]   ext,
  output fpd_pkg::fpd_op_e  op,
  output fpd_pkg::fpd_fmt_e fmt,
  output logic              has_stat,
  output logic              hit
);
  import fpd_pkg::*;

  // ****************************************************************
  // Lookup
  // ****************************************************************
  always_comb
  begin
    op       = OP_NONE;
    has_stat = 1'b0;
    hit    = 1'b1;
    fmt    = opc_one ? FMT_PAIRED : FMT_WHOLE;
    case (ext)
      6'h10: op = OP_MERGE_S;
      6'h11: op = OP_MERGE_NS;
      6'h12: op = OP_MERGE_SE;
      6'h14: begin op = OP_MIN;  has_stat = 1'b1; end
      6'h15: begin op = OP_MAX;  has_stat = 1'b1; end
      6'h16: begin op = OP_AMIN; has_stat = 1'b1; end
      6'h17: begin op = OP_AMAX; has_stat = 1'b1; end
      6'h18: begin op = OP_CVT_FX;        has_stat = 1'b1; end
      6'h19: begin op = OP_CVT_FXU;       has_stat = 1'b1; end
      6'h1A: begin op = OP_CVT_FX_TRUNC;  has_stat = 1'b1; end
      6'h1B: begin op = OP_CVT_FXU_TRUNC; has_stat = 1'b1; end
      default:
      begin
        hit = 1'b0;
      end
    endcase
    if (!hit && !opc_one)
    begin
      hit = 1'b1;
      case (ext)
        6'h00: op = OP_BREAK;
        6'h01: op = OP_NOP;
        6'h04: begin op = OP_SETC; has_stat = 1'b1; end
        6'h05: begin op = OP_CLRF; has_stat = 1'b1; end
        6'h08: begin op = OP_CHKF; has_stat = 1'b1; end
        6'h1C: op = OP_CVT_XF;
        6'h28: op = OP_PACK;
        6'h2C: op = OP_AND;
        6'h2D: op = OP_ANDCM;
        6'h2E: op = OP_OR;
        6'h2F: op = OP_XOR;
        6'h34: op = OP_SWAP;
        6'h35: op = OP_SWAP_NL;
        6'h36: op = OP_SWAP_NR;
        6'h39: op = OP_MIX_LR;
        6'h3A: op = OP_MIX_R;
        6'h3B: op = OP_MIX_L;
        6'h3C: op = OP_SXT_R;
        6'h3D: op = OP_SXT_L;
        default: hit = 1'b0;
      endcase
    end
    else if (!hit && opc_one)
    begin
      hit      = 1'b1;
      has_stat = 1'b1;
      case (ext)
        6'h30: op = OP_CMP_EQ;
        6'h31: op = OP_CMP_LT;
        6'h32: op = OP_CMP_LE;
        6'h33: op = OP_CMP_UNORD;
        6'h34: op = OP_CMP_NEQ;
        6'h35: op = OP_CMP_NLT;
        6'h36: op = OP_CMP_NLE;
        6'h37: op = OP_CMP_ORD;
        default:
        begin
          hit      = 1'b0;
          has_stat = 1'b0;
        end
      endcase
    end
  end
endmodule

// File: rtl/fpd_decoder.sv
// Single-cycle decoder for floating-point instruction slots
`timescale 1ns/1ps
`include "fpd_regs.svh"
module fpd_decoder (
  input  wire logic             CLK_SYS,
  input  wire logic             RST,
  input  wire logic             CE,
  input  wire logic             SLOT_VALID,
  input  wire fpd_pkg::fpd_slot_t SLOT,
  output logic                  OUT_VALID,
  output fpd_pkg::fpd_grp_e     OP_GROUP,
  output fpd_pkg::fpd_op_e      OP_ID,
  output fpd_pkg::fpd_fmt_e     OP_FORMAT,
  output fpd_pkg::fpd_stat_t    STATUS_FIELD_SELECT,
  output logic                  HAS_STATUS_FIELD,
  output logic                  WRITES_PREDICATE,
  output logic                  UNCONDITIONAL_FORM,
  output logic                  UNASSIGNED,
  output fpd_pkg::fpd_reg_t     DEST_REG,
  output fpd_pkg::fpd_reg_t     SRC1_REG,
  output fpd_pkg::fpd_reg_t     SRC2_REG,
  output fpd_pkg::fpd_reg_t     SRC3_REG,
  output fpd_pkg::fpd_pred_t    QUALIFYING_PREDICATE
);
  import fpd_pkg::*;

  // ****************************************************************
  // Slot fields
  // ****************************************************************
  logic [3:0] major_opc;
  logic       q_bit;
  logic       x_bit;
  logic       ta_bit;
  logic [1:0] stat_field;
  logic [1:0] multiply_form_select;
  logic [5:0] six_bit_extension;
  fpd_reg_t   dst_f;
  fpd_reg_t   src1_f;
  fpd_reg_t   src2_f;
  fpd_reg_t   src3_f;
  fpd_pred_t  pred_f;

  assign major_opc            = SLOT[`FPD_OPC_HI:`FPD_OPC_LO];
  assign q_bit                = SLOT[`FPD_Q_BIT];
  assign x_bit                = SLOT[`FPD_X_BIT];
  assign ta_bit               = SLOT[`FPD_TA_BIT];
  assign stat_field           = SLOT[`FPD_STAT_HI:`FPD_STAT_LO];
  // Same bits as the status field; meaning depends on major opcode
  assign multiply_form_select = SLOT[`FPD_STAT_HI:`FPD_STAT_LO];
  // Upper pair 32:31 and lower nibble 30:27 form one contiguous field
  assign six_bit_extension    = SLOT[`FPD_EXT_HI:`FPD_EXT_LO];

  // ****************************************************************
  // Register index slices
  // ****************************************************************
  fpd_field #(.LSB(`FPD_DST_LO), .W(`FPD_REG_W)) u_dst (
    .slot  (SLOT),
    .field (dst_f)
  );

  fpd_field #(.LSB(`FPD_SRC1_LO), .W(`FPD_REG_W)) u_src1 (
    .slot  (SLOT),
    .field (src1_f)
  );

  fpd_field #(.LSB(`FPD_SRC2_LO), .W(`FPD_REG_W)) u_src2 (
    .slot  (SLOT),
    .field (src2_f)
  );

  fpd_field #(.LSB(`FPD_SRC3_LO), .W(`FPD_REG_W)) u_src3 (
    .slot  (SLOT),
    .field (src3_f)
  );

  fpd_field #(.LSB(`FPD_PRED_LO), .W(`FPD_PRED_W)) u_pred (
    .slot  (SLOT),
    .field (pred_f)
  );

  // ****************************************************************
  // Extension lookup
  // ****************************************************************
  fpd_op_e  ext_op;
  fpd_fmt_e ext_fmt;
  logic     ext_has_stat;
  logic     ext_hit;

  fpd_ext_lookup u_ext (
    .opc_one (major_opc == `FPD_OPC_MISC1),
    .ext     (six_bit_extension),
    .op      (ext_op),
    .fmt     (ext_fmt),
    .has_stat (ext_has_stat),
    .hit     (ext_hit)
  );

  // ****************************************************************
  // Decode state
  // ****************************************************************
  logic      valid_reg;
  logic      valid_next;
  fpd_grp_e  grp_reg;
  fpd_grp_e  grp_next;
  fpd_op_e   op_reg;
  fpd_op_e   op_next;
  fpd_fmt_e  fmt_reg;
  fpd_fmt_e  fmt_next;
  fpd_stat_t stat_reg;
  fpd_stat_t stat_next;
  logic      has_stat_reg;
  logic      has_stat_next;
  logic      wr_pred_reg;
  logic      wr_pred_next;
  logic      unc_reg;
  logic      unc_next;
  logic      unassigned_reg;
  logic      unassigned_next;

  // Classification is purely a function of the slot; one stage of
  // registers keeps the dispatch path short at the cost of a cycle.
  always_comb
  begin
    valid_next      = SLOT_VALID;
    grp_next        = GRP_NONE;
    op_next         = OP_NONE;
    fmt_next        = FMT_WHOLE;
    stat_next       = `FPD_RST_STAT;
    has_stat_next   = 1'b0;
    wr_pred_next    = 1'b0;
    unc_next        = 1'b0;
    unassigned_next = 1'b0;
    case (major_opc)
      `FPD_OPC_MISC0,
      `FPD_OPC_MISC1:
      begin
        if (x_bit)
        begin
          grp_next     = GRP_RECIP;
          op_next      = q_bit ? OP_RSQRTA : OP_RCPA;
          fmt_next     = (major_opc == `FPD_OPC_MISC1) ? FMT_PAIRED : FMT_WHOLE;
          has_stat_next = 1'b1;
          wr_pred_next = 1'b1;
        end
        else
        begin
          grp_next        = GRP_MISC;
          op_next         = ext_op;
          fmt_next        = ext_fmt;
          has_stat_next   = ext_has_stat;
          wr_pred_next    = 1'b0;
          unassigned_next = !ext_hit;
        end
      end
      `FPD_OPC_CMP:
      begin
        grp_next      = GRP_CMP;
        has_stat_next = 1'b1;
        wr_pred_next = 1'b1;
        unc_next     = ta_bit;
        case ({x_bit, q_bit})
          2'b00: op_next = OP_CMP_EQ;
          2'b01: op_next = OP_CMP_LT;
          2'b10: op_next = OP_CMP_LE;
          2'b11: op_next = OP_CMP_UNORD;
          default: op_next = OP_NONE;
        endcase
      end
      `FPD_OPC_CLASS:
      begin
        grp_next     = GRP_CLASS;
        op_next      = OP_CLASS;
        wr_pred_next = 1'b1;
        unc_next     = ta_bit;
      end
      `FPD_OPC_XMA:
      begin
        grp_next = GRP_XMA_SEL;
        if (!q_bit)
        begin
          op_next = OP_SELECT;
        end
        else
        begin
          case (multiply_form_select)
            `FPD_MUL_LOW: op_next = OP_XMA_L;
            `FPD_MUL_HU:  op_next = OP_XMA_HU;
            `FPD_MUL_H:   op_next = OP_XMA_H;
            default:     unassigned_next = 1'b1;
          endcase
        end
      end
      default:
      begin
        if (major_opc >= `FPD_OPC_FMA_LO && major_opc <= `FPD_OPC_FMA_HI)
        begin
          grp_next      = GRP_FMA;
          has_stat_next = 1'b1;
          case (major_opc[2:1])
            2'b00:   op_next = OP_MA;
            2'b01:   op_next = OP_MS;
            default: op_next = OP_NMA;
          endcase
          // Odd opcodes are double or paired, even ones whole or single
          if (major_opc[0])
          begin
            fmt_next = q_bit ? FMT_PAIRED : FMT_DOUBLE;
          end
          else
          begin
            fmt_next = q_bit ? FMT_SINGLE : FMT_WHOLE;
          end
        end
        else
        begin
          unassigned_next = 1'b1;
        end
      end
    endcase
    // Status field is reported only where the operation carries one
    if (has_stat_next)
    begin
      stat_next = stat_field;
    end
    // An unassigned encoding never reports an operation
    if (unassigned_next)
    begin
      grp_next     = GRP_NONE;
      op_next      = OP_NONE;
      fmt_next      = FMT_WHOLE;
      has_stat_next = 1'b0;
      stat_next     = `FPD_RST_STAT;
      wr_pred_next = 1'b0;
      unc_next     = 1'b0;
    end
    // Idle cycles present a quiet, all-zero decode
    if (!SLOT_VALID)
    begin
      grp_next        = GRP_NONE;
      op_next         = OP_NONE;
      fmt_next        = FMT_WHOLE;
      has_stat_next   = 1'b0;
      stat_next       = `FPD_RST_STAT;
      wr_pred_next    = 1'b0;
      unc_next        = 1'b0;
      unassigned_next = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      valid_reg      <= 1'b0;
      grp_reg        <= GRP_NONE;
      op_reg         <= OP_NONE;
      fmt_reg        <= FMT_WHOLE;
      stat_reg       <= `FPD_RST_STAT;
      has_stat_reg   <= 1'b0;
      wr_pred_reg    <= 1'b0;
      unc_reg        <= 1'b0;
      unassigned_reg <= 1'b0;
    end
    else if (CE)
    begin
      valid_reg      <= valid_next;
      grp_reg        <= grp_next;
      op_reg         <= op_next;
      fmt_reg        <= fmt_next;
      stat_reg       <= stat_next;
      has_stat_reg   <= has_stat_next;
      wr_pred_reg    <= wr_pred_next;
      unc_reg        <= unc_next;
      unassigned_reg <= unassigned_next;
    end
  end

  // ****************************************************************
  // Operand state
  // ****************************************************************
  fpd_reg_t dst_reg;
  fpd_reg_t dst_next;
  fpd_reg_t src1_reg;
  fpd_reg_t src1_next;
  fpd_reg_t src2_reg;
  fpd_reg_t src2_next;
  fpd_reg_t src3_reg;
  fpd_reg_t src3_next;
  fpd_pred_t pred_reg;
  fpd_pred_t pred_next;

  // Indices are passed raw; formats without a given source leave the
  // unused slice for the execution side to ignore.
  always_comb
  begin
    dst_next  = `FPD_RST_REG;
    src1_next = `FPD_RST_REG;
    src2_next = `FPD_RST_REG;
    src3_next = `FPD_RST_REG;
    pred_next = `FPD_RST_PRED;
    if (SLOT_VALID)
    begin
      dst_next  = dst_f;
      src1_next = src1_f;
      src2_next = src2_f;
      src3_next = src3_f;
      pred_next = pred_f;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      dst_reg  <= `FPD_RST_REG;
      src1_reg <= `FPD_RST_REG;
      src2_reg <= `FPD_RST_REG;
      src3_reg <= `FPD_RST_REG;
      pred_reg <= `FPD_RST_PRED;
    end
    else if (CE)
    begin
      dst_reg  <= dst_next;
      src1_reg <= src1_next;
      src2_reg <= src2_next;
      src3_reg <= src3_next;
      pred_reg <= pred_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign OUT_VALID            = valid_reg;
  assign OP_GROUP             = grp_reg;
  assign OP_ID                = op_reg;
  assign OP_FORMAT            = fmt_reg;
  assign STATUS_FIELD_SELECT  = stat_reg;
  assign HAS_STATUS_FIELD     = has_stat_reg;
  assign WRITES_PREDICATE     = wr_pred_reg;
  assign UNCONDITIONAL_FORM   = unc_reg;
  assign UNASSIGNED           = unassigned_reg;
  assign DEST_REG             = dst_reg;
  assign SRC1_REG             = src1_reg;
  assign SRC2_REG             = src2_reg;
  assign SRC3_REG             = src3_reg;
  assign QUALIFYING_PREDICATE = pred_reg;

endmodule

// File: tb/fpd_decoder_chk.sv
// Concurrent checks on the slot decoder ports
`timescale 1ns/1ps
module fpd_decoder_chk (
  input wire logic                CLK_SYS,
  input wire logic                RST,
  input wire logic                CE,
  input wire logic                SLOT_VALID,
  input wire fpd_pkg::fpd_slot_t  SLOT,
  input wire logic                OUT_VALID,
  input wire fpd_pkg::fpd_grp_e   OP_GROUP,
  input wire fpd_pkg::fpd_op_e    OP_ID,
  input wire fpd_pkg::fpd_fmt_e   OP_FORMAT,
  input wire fpd_pkg::fpd_stat_t  STATUS_FIELD_SELECT,
  input wire logic                HAS_STATUS_FIELD,
  input wire logic                WRITES_PREDICATE,
  input wire logic                UNCONDITIONAL_FORM,
  input wire logic                UNASSIGNED,
  input wire fpd_pkg::fpd_reg_t   DEST_REG,
  input wire fpd_pkg::fpd_reg_t   SRC1_REG,
  input wire fpd_pkg::fpd_reg_t   SRC2_REG,
  input wire fpd_pkg::fpd_reg_t   SRC3_REG,
  input wire fpd_pkg::fpd_pred_t  QUALIFYING_PREDICATE
);
  import fpd_pkg::*;

  // Slot held alongside the outputs it produced
  fpd_slot_t   slot_reg;
  fpd_slot_t   slot_next;
  logic [3:0]  opc;

  always_comb
  begin
    slot_next = RST ? '0 : (CE ? SLOT : slot_reg);
  end

  always_ff @(posedge CLK_SYS)
  begin
    slot_reg <= slot_next;
  end

  assign opc = slot_reg[40:37];

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  a_valid_follow:
    assert property (CE |=> OUT_VALID == $past(SLOT_VALID)) else $error("valid not following slot");
  a_hold_frozen:
    assert property (!CE |=> $stable(OP_ID) && $stable(OUT_VALID) && $stable(DEST_REG)) else $error("output moved");
  a_invalid_clear:
    assert property (CE && !SLOT_VALID |=> OP_GROUP == GRP_NONE && !UNASSIGNED && DEST_REG == 7'h00)
    else $error("idle output not clear");
  a_index_pass:
    assert property (OUT_VALID |-> {DEST_REG, SRC1_REG, SRC2_REG, SRC3_REG, QUALIFYING_PREDICATE} ==
      {slot_reg[12:6], slot_reg[19:13], slot_reg[26:20], slot_reg[33:27], slot_reg[5:0]})
    else $error("register index wrong");
  a_stat_report:
    assert property (OUT_VALID |-> STATUS_FIELD_SELECT == (HAS_STATUS_FIELD ? slot_reg[35:34] : 2'h0))
    else $error("status field wrong");
  a_fma_family:
    assert property (OUT_VALID && opc inside {[4'h8:4'hd]} |-> OP_GROUP == GRP_FMA &&
      OP_ID == OP_MA + (opc - 8) / 2 && OP_FORMAT == {opc[0], slot_reg[36]}) else $error("fma decode wrong");
  a_recip_pick:
    assert property (OUT_VALID && opc < 2 && slot_reg[33] |-> OP_GROUP == GRP_RECIP && WRITES_PREDICATE &&
      OP_ID == (slot_reg[36] ? OP_RSQRTA : OP_RCPA) && OP_FORMAT == (opc[0] ? FMT_PAIRED : FMT_WHOLE))
    else $error("reciprocal decode wrong");
  a_cmp_pick:
    assert property (OUT_VALID && opc == 4'h4 |-> OP_ID == OP_CMP_EQ + {slot_reg[33], slot_reg[36]} &&
      UNCONDITIONAL_FORM == slot_reg[12] && WRITES_PREDICATE) else $error("compare decode wrong");
  a_class_pick:
    assert property (OUT_VALID && opc == 4'h5 |-> OP_ID == OP_CLASS && UNCONDITIONAL_FORM == slot_reg[12])
    else $error("class decode wrong");
  a_xma_pick:
    assert property (OUT_VALID && opc == 4'he |-> UNASSIGNED == (slot_reg[36] && slot_reg[35:34] == 2'h1) &&
      (slot_reg[36] || OP_ID == OP_SELECT)) else $error("opcode E decode wrong");
  a_major_unused:
    assert property (OUT_VALID && opc inside {4'h2, 4'h3, 4'h6, 4'h7, 4'hf} |-> UNASSIGNED && OP_GROUP == GRP_NONE)
    else $error("unused major opcode accepted");
  a_minmax_ext:
    assert property (OUT_VALID && opc < 2 && !slot_reg[33] && slot_reg[32:27] inside {[6'h14:6'h17]} |->
      OP_ID == OP_MIN + slot_reg[28:27]) else $error("min max decode wrong");
endmodule

bind fpd_decoder fpd_decoder_chk i_fpd_decoder_chk (.CLK_SYS, .RST, .CE, .SLOT_VALID, .SLOT, .OUT_VALID,
  .OP_GROUP, .OP_ID, .OP_FORMAT, .STATUS_FIELD_SELECT, .HAS_STATUS_FIELD, .WRITES_PREDICATE,
  .UNCONDITIONAL_FORM, .UNASSIGNED, .DEST_REG, .SRC1_REG, .SRC2_REG, .SRC3_REG, .QUALIFYING_PREDICATE);

// File: tb/fpd_exec_model.sv
// Execution-side model that counts illegal-operation indications
`timescale 1ns/1ps
module fpd_exec_model (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic out_valid,
  input  wire logic unassigned,
  output int        illegal_count
);
  // A result is consumed once, at the edge after the enabled edge that loads it
  logic fresh_reg;
  logic fresh_next;
  int   cnt_reg;
  int   cnt_next;

  always_comb
  begin
    fresh_next = !rst && ce;
    cnt_next   = rst ? 0 : cnt_reg + int'(fresh_reg && out_valid && unassigned);
  end

  always_ff @(posedge clk_sys)
  begin
    fresh_reg <= fresh_next;
    cnt_reg   <= cnt_next;
  end

  assign illegal_count = cnt_reg;
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the floating-point slot decoder
`timescale 1ns/1ps
module tb_top;
  import fpd_pkg::*;
  logic CLK_SYS = 0;
  logic RST = 1;
  logic CE = 0;
  logic SLOT_VALID = 0;
  fpd_slot_t SLOT = '0;
  logic OUT_VALID, HAS_STATUS_FIELD, WRITES_PREDICATE, UNCONDITIONAL_FORM, UNASSIGNED;
  fpd_grp_e OP_GROUP;
  fpd_op_e OP_ID;
  fpd_fmt_e OP_FORMAT;
  fpd_stat_t STATUS_FIELD_SELECT;
  fpd_reg_t DEST_REG, SRC1_REG, SRC2_REG, SRC3_REG;
  fpd_pred_t QUALIFYING_PREDICATE;
  int n_fail = 0;
  int n_compared = 0;
  int n_ill = 0;
  int got_ill;
  logic [31:0] seed = 32'h0000_0007;
  logic [52:0] nq[$];
  logic [52:0] last;
  fpd_slot_t s;
  logic [31:0] r;
  wire logic [17:0] dec_w = {OUT_VALID, OP_GROUP, OP_ID, OP_FORMAT, STATUS_FIELD_SELECT, HAS_STATUS_FIELD,
    WRITES_PREDICATE, UNCONDITIONAL_FORM, UNASSIGNED};
  wire logic [33:0] idx_w = {DEST_REG, SRC1_REG, SRC2_REG, SRC3_REG, QUALIFYING_PREDICATE};

  always #10 CLK_SYS = ~CLK_SYS;

  fpd_decoder i_fpd_decoder (.CLK_SYS, .RST, .CE, .SLOT_VALID, .SLOT, .OUT_VALID, .OP_GROUP, .OP_ID, .OP_FORMAT,
    .STATUS_FIELD_SELECT, .HAS_STATUS_FIELD, .WRITES_PREDICATE, .UNCONDITIONAL_FORM, .UNASSIGNED, .DEST_REG,
    .SRC1_REG, .SRC2_REG, .SRC3_REG, .QUALIFYING_PREDICATE);
  fpd_exec_model i_fpd_exec_model (.clk_sys(CLK_SYS), .rst(RST), .ce(CE), .out_valid(OUT_VALID),
    .unassigned(UNASSIGNED), .illegal_count(got_ill));

  // ****************************************************************
  // Expected decode: {format-care, decode flags, indices}
  // ****************************************************************
  function automatic logic [52:0] exp_note(input fpd_slot_t s, input logic v);
    fpd_grp_e g;
    fpd_op_e o;
    fpd_fmt_e f;
    logic hs, wp, un, cf;
    logic [5:0] x;
    logic [3:0] m;
    g = GRP_MISC; o = OP_NONE; f = FMT_WHOLE; hs = 0; wp = 0; un = 0; cf = 1;
    x = s[32:27];
    m = s[40:37];
    if (!v) return {1'b1, 52'h0};
    if (m < 2)
    begin
      f = m[0] ? FMT_PAIRED : FMT_WHOLE;
      if (s[33])
      begin
        g = GRP_RECIP; hs = 1; wp = 1;
        o = s[36] ? OP_RSQRTA : OP_RCPA;
      end
      else if (x inside {[6'h10:6'h12]}) o = fpd_op_e'(OP_MERGE_S + x - 16);
      else if (x inside {[6'h14:6'h1b]})
      begin
        o = fpd_op_e'(OP_MIN + x - 20);
        hs = 1;
      end
      else if (m[0] && x inside {[6'h30:6'h37]})
      begin
        o = fpd_op_e'(OP_CMP_EQ + x - 48);
        hs = 1;
      end
      else if (!m[0])
      begin
        hs = x inside {6'h04, 6'h05, 6'h08};
        case (x)
          6'h00: o = OP_BREAK;
          6'h01: o = OP_NOP;
          6'h04: o = OP_SETC;
          6'h05: o = OP_CLRF;
          6'h08: o = OP_CHKF;
          6'h1c: o = OP_CVT_XF;
          6'h28: o = OP_PACK;
          default:
            if (x inside {[6'h2c:6'h2f]}) o = fpd_op_e'(OP_AND + x - 44);
            else if (x inside {[6'h34:6'h36]}) o = fpd_op_e'(OP_SWAP + x - 52);
            else if (x inside {[6'h39:6'h3d]}) o = fpd_op_e'(OP_MIX_LR + x - 57);
        endcase
      end
    end
    else if (m == 4'h4)
    begin
      g = GRP_CMP; hs = 1; wp = 1; un = s[12]; cf = 0;
      o = fpd_op_e'(OP_CMP_EQ + {s[33], s[36]});
    end
    else if (m == 4'h5)
    begin
      g = GRP_CLASS; o = OP_CLASS; wp = 1; un = s[12]; cf = 0;
    end
    else if (m inside {[4'h8:4'hd]})
    begin
      g = GRP_FMA; hs = 1;
      o = fpd_op_e'(OP_MA + (m - 8) / 2);
      f = fpd_fmt_e'({m[0], s[36]});
    end
    else if (m == 4'he)
    begin
      g = GRP_XMA_SEL; cf = 0;
      if (!s[36]) o = OP_SELECT;
      else if (s[35:34] != 2'h1) o = fpd_op_e'(OP_XMA_L + s[35:34] - (s[35] ? 1 : 0));
    end
    if (o == OP_NONE)
    begin
      g = GRP_NONE; hs = 0; wp = 0; un = 0; cf = 0;
    end
    return {cf, 1'b1, g, o, f, hs ? s[35:34] : 2'h0, hs, wp, un, o == OP_NONE,
      s[12:6], s[19:13], s[26:20], s[33:27], s[5:0]};
  endfunction

  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // ****************************************************************
  // Drivers, compares and closing
  // ****************************************************************
  task automatic put(input fpd_slot_t v_slot, input logic v, input logic ce);
    @(posedge CLK_SYS);
    #2;
    SLOT = v_slot;
    SLOT_VALID = v;
    CE = ce;
    if (ce) nq.push_back(exp_note(v_slot, v));
  endtask

  task automatic reset();
    @(posedge CLK_SYS);
    #2;
    RST = 1;
    CE = 0;
    repeat (16) @(posedge CLK_SYS);
    #2;
    RST = 0;
  endtask

  task automatic report(input logic [63:0] e, input logic [63:0] g);
    n_compared++;
    if (e !== g)
    begin
      n_fail++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic cmp_dec(input logic [52:0] n, input logic [17:0] g);
    logic [17:0] e;
    e = n[51:34];
    if (!n[52])
    begin
      e[7:6] = 2'h0;
      g[7:6] = 2'h0;
    end
    report(64'(e), 64'(g));
  endtask

  task automatic cmp_idx(input logic [33:0] e, input logic [33:0] g);
    report(64'(e), 64'(g));
  endtask

  task automatic cmp_cnt(input int e, input int g);
    report(64'(e), 64'(g));
  endtask

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Outputs hold the last enabled result, zero in reset
  always @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      last = {1'b1, 52'h0};
      n_ill = 0;
    end
    else if (CE && nq.size() > 0)
    begin
      last = nq.pop_front();
      n_ill = n_ill + int'(last[34]);
    end
    #1;
    cmp_dec(last, dec_w);
    cmp_idx(last[33:0], idx_w);
  end

  initial
  begin
    #200_000;
    n_fail++;
    stop_test();
  end

  initial
  begin
    reset();
    for (int m = 0; m < 16; m++)
      for (int k = 0; k < 32; k++)
      begin
        s = 41'({xs(), xs()});
        s[40:37] = m[3:0];
        {s[36:33], s[12]} = k[4:0];
        put(s, 1, 1);
      end
    for (int k = 0; k < 128; k++)
    begin
      s = 41'({xs(), xs()});
      s[40:37] = {3'h0, k[6]};
      s[33] = 1'b0;
      s[32:27] = k[5:0];
      put(s, 1, 1);
    end
    repeat (400)
    begin
      s = 41'({xs(), xs()});
      r = xs();
      put(s, r[0] | r[1], r[2] | r[3] | r[4]);
    end
    reset();
    repeat (40)
    begin
      s = 41'({xs(), xs()});
      r = xs();
      put(s, r[0] | r[1], r[2] | r[3]);
    end
    put(s, 0, 0);
    repeat (3) @(posedge CLK_SYS);
    #1;
    cmp_cnt(n_ill, got_ill);
    stop_test();
  end
endmodule
